// ### design/cell_monitor_pkg.sv
// constants for the cell monitor sleep, wake and over-temperature control block
package cell_monitor_pkg;
  // register word addresses (byte addresses of aligned 32-bit words)
  localparam logic [7:0] ADDR_CTRL = 8'h00; // sleep select bits
  localparam logic [7:0] ADDR_BAL = 8'h04; // balance switch bits
  localparam logic [7:0] ADDR_OTCFG = 8'h18; // over-temperature config
  localparam logic [7:0] ADDR_STATUS = 8'h1c; // chip status
  localparam logic [7:0] ADDR_IRQFLAG = 8'h24; // sticky interrupt flags
  localparam logic [7:0] ADDR_IRQMASK = 8'h28; // interrupt mask
  localparam logic [7:0] ADDR_GATE = 8'h2c; // charge gate control
  // control register field positions
  localparam int SLP_HI_BIT = 7;
  localparam int SLP_LO_BIT = 6;
  // over-temperature config field positions
  localparam int OT_EN_BIT = 7;
  localparam int OT_ACT_BIT = 4;
  // status register field positions
  localparam int ST_WAKE_A = 0;
  localparam int ST_WAKE_B = 1;
  localparam int ST_OT = 2;
  localparam int ST_LOCK = 3;
  localparam int ST_SLEEP = 4;
  localparam int ST_GATE = 5;
  // charge gate control bit and the all-off balance pattern
  localparam int GATE_BIT = 0;
  localparam logic [7:0] BAL_ALL_OFF = 8'h00;
  // interrupt flag positions
  localparam int IRQ_OT = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_W = 2;
  // reset values
  localparam logic [1:0] SLP_RESET = 2'h0;
  localparam logic [7:0] BAL_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] MASK_RESET = 2'h3;
  // sleep select code that enters sleep (hi=0, lo=1)
  localparam logic [1:0] SLP_ENTER = 2'h1;
  // wake pulse qualification time
  localparam int CLK_HZ = 25_000_000;
  localparam int WAKE_MIN_US = 1000;
  localparam int WAKE_CYCLES = (CLK_HZ / 1_000_000) * WAKE_MIN_US; // least time, exact
  typedef enum logic [0:0] {
    MODE_NORMAL = 1'b0,
    MODE_SLEEP = 1'b1
  } mode_e;
endpackage

// ### design/cell_monitor_ctrl.sv
// sleep, wake and over-temperature control logic of the cell monitor
// Function
// - sleep command ignored while any wake high
// - qualified wake pulse restores regulator, normal mode
// - wake status high means wake event occurred
// - charge gate output follows its control input
// - over-temp detection needs enable and balance on
// - over-temp sets status; flag only when unmasked
// - status clears below threshold minus hysteresis
// - action bit: over-temp turns off, locks balance
// - lock released only by writing zero balance
// - wake status a set above wake threshold
// - wake status a clears when source removed
// - wake status readable by host
// - balance stays on until zero or sleep
// - sleep shuts down all outputs; irq is not gated by sleep and stays live
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module cell_monitor_ctrl
  import cell_monitor_pkg::*;
#(
  parameter int WAKE_COUNT = WAKE_CYCLES // qualifying wake width in clocks
) (
  input wire logic clk_sys, // system clock, 25 MHz
  input wire logic rst, // async reset, active high
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic hv_wake_pin_a, // wake comparator a, above threshold
  input wire logic hv_wake_pin_b, // wake comparator b, above threshold
  input wire logic overtemp_hot, // junction above detection threshold
  input wire logic overtemp_cool, // junction below threshold minus hysteresis
  output logic regulator_output, // regulator enable
  output logic charge_gate_out, // charge gate drive, high = pump level
  output logic [7:0] balance_switch_bits, // balance switch drives
  output logic irq // level interrupt
);

  // the block leaves reset in normal mode with the regulator on; all pins
  // above are levels except wb_ack_o, a one-cycle pulse, and the clk_sys edge

  // every comparator pin level is sampled twice before use: the comparators switch
  // on analogue events with no relation to clk_sys
  // input synchronisers, first stage read only by second
  logic [3:0] syncA;
  logic [3:0] syncB;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      syncA <= 4'h0;
      syncB <= 4'h0;
    end else begin
      syncA <= {overtemp_cool, overtemp_hot, hv_wake_pin_b, hv_wake_pin_a};
      syncB <= syncA;
    end
  end

  logic wakeA;
  logic wakeB;
  logic hot;
  logic cool;
  assign wakeA = syncB[0];
  assign wakeB = syncB[1];
  assign hot = syncB[2];
  assign cool = syncB[3];

  // registers
  mode_e mode;
  logic [1:0] sleepSel;
  logic [7:0] balReg;
  logic otEnable;
  logic otAction;
  logic otStatus;
  logic balLock;
  logic gateCtrl;
  logic [IRQ_W-1:0] irqFlag;
  logic [IRQ_W-1:0] irqMask;
  logic [31:0] wakeCount;
  logic [1:0] wakeStatus;
  logic ack;
  logic [31:0] rdData;

  // bus decode
  // only byte lane 0 carries register bits; a write without it is dropped
  logic access;
  logic wr;
  logic selLo;
  logic hitCtrl;
  logic hitBal;
  logic hitOtcfg;
  logic hitStatus;
  logic hitFlag;
  logic hitMask;
  logic hitGate;
  assign access = wb_cyc_i && wb_stb_i && !ack;
  assign wr = access && wb_we_i;
  assign selLo = wb_sel_i[0];
  assign hitCtrl = wb_adr_i == ADDR_CTRL;
  assign hitBal = wb_adr_i == ADDR_BAL;
  assign hitOtcfg = wb_adr_i == ADDR_OTCFG;
  assign hitStatus = wb_adr_i == ADDR_STATUS;
  assign hitFlag = wb_adr_i == ADDR_IRQFLAG;
  assign hitMask = wb_adr_i == ADDR_IRQMASK;
  assign hitGate = wb_adr_i == ADDR_GATE;

  // wake status follows the comparators while asleep or awake
  assign wakeStatus = {wakeB, wakeA};
  logic anyWake;
  assign anyWake = wakeA || wakeB;

  // sleep command: accepted only with both wake signals low
  // a refused command leaves the control bits as they were
  logic wrCtrl;
  logic sleepCmd;
  logic [1:0] wrSleepSel;
  assign wrCtrl = wr && hitCtrl && selLo;
  assign wrSleepSel = {wb_dat_i[SLP_HI_BIT], wb_dat_i[SLP_LO_BIT]};
  assign sleepCmd = wrCtrl && (wrSleepSel == SLP_ENTER) && !anyWake;

  // wake qualification: a wake pin must stay high for the full count
  // the count runs only while asleep, so a level already high at sleep
  // entry is timed from the entry edge; sleep is refused then anyway
  logic wakeQualified;
  assign wakeQualified = anyWake && (wakeCount >= WAKE_COUNT - 1);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wakeCount <= 32'h0;
    end else if (mode == MODE_SLEEP && anyWake && !wakeQualified) begin
      wakeCount <= wakeCount + 32'h1;
    end else begin
      wakeCount <= 32'h0; // short pulse restarts the count
    end
  end

  // operating mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode <= MODE_NORMAL;
    end else if (mode == MODE_NORMAL && sleepCmd) begin
      mode <= MODE_SLEEP;
    end else if (mode == MODE_SLEEP && wakeQualified) begin
      mode <= MODE_NORMAL;
    end
  end

  logic asleep;
  assign asleep = (mode == MODE_SLEEP);

  // control register keeps the written code; abandoned while waking
  // waking returns the code to its reset value so a read shows normal
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sleepSel <= SLP_RESET;
    end else if (mode == MODE_SLEEP && wakeQualified) begin
      sleepSel <= SLP_RESET;
    end else if (wrCtrl && !(wrSleepSel == SLP_ENTER && anyWake)) begin
      sleepSel <= wrSleepSel;
    end
  end

  // over-temperature detection and status with hysteresis
  // hysteresis comes from the two comparator levels, not from a timer
  logic otActive;
  logic otEvent;
  assign otActive = otEnable && (balReg != BAL_ALL_OFF);
  assign otEvent = otActive && hot && !otStatus;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      otStatus <= 1'b0;
    end else if (otActive && hot) begin
      otStatus <= 1'b1;
    end else if (cool || !otEnable) begin
      otStatus <= 1'b0;
    end
  end

  // balance switches with over-temperature lock
  // a trip wins over a same-cycle write, so the write cannot undo it
  logic wrBal;
  logic [7:0] wrBalData;
  assign wrBal = wr && hitBal && selLo;
  assign wrBalData = wb_dat_i[7:0];
  logic otTrip;
  logic balZeroWr;
  assign otTrip = otEvent && otAction;
  assign balZeroWr = wrBal && (wrBalData == BAL_ALL_OFF);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      balLock <= 1'b0;
    end else if (otTrip) begin
      balLock <= 1'b1;
    end else if (balZeroWr) begin
      balLock <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      balReg <= BAL_RESET;
    end else if (sleepCmd || otTrip) begin
      balReg <= BAL_RESET;
    end else if ((wrBal && !balLock) || balZeroWr) begin
      balReg <= wrBalData;
    end
  end

  // write strobes for the plain software registers
  logic wrOtcfg;
  logic wrGate;
  logic wrMask;
  logic wrFlag;
  assign wrOtcfg = wr && hitOtcfg && selLo;
  assign wrGate = wr && hitGate && selLo;
  assign wrMask = wr && hitMask && selLo;
  assign wrFlag = wr && hitFlag && selLo;

  // over-temperature config; clearing enable also drops the status
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      otEnable <= 1'b0;
      otAction <= 1'b0;
    end else if (wrOtcfg) begin
      otEnable <= wb_dat_i[OT_EN_BIT];
      otAction <= wb_dat_i[OT_ACT_BIT];
    end
  end

  // charge gate control bit, drives the gate only while awake
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gateCtrl <= 1'b0;
    end else if (wrGate) begin
      gateCtrl <= wb_dat_i[GATE_BIT];
    end
  end

  // interrupt mask; all masked out of reset so no stray irq
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqMask <= MASK_RESET;
    end else if (wrMask) begin
      irqMask <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // sticky flags: masked over-temp never sets its flag; set wins over clear
  // the wake flag only spares the host a poll of the status word
  logic [IRQ_W-1:0] flagSet;
  logic [IRQ_W-1:0] flagClr;
  logic wakeRise;
  logic anyWakeD;
  // delayed copy resets low, the idle pin level, so no false rise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      anyWakeD <= 1'b0;
    end else begin
      anyWakeD <= anyWake;
    end
  end
  assign wakeRise = anyWake && !anyWakeD;
  assign flagSet[IRQ_OT] = otEvent && !irqMask[IRQ_OT];
  assign flagSet[IRQ_WAKE] = wakeRise && !irqMask[IRQ_WAKE];
  assign flagClr = wrFlag ? wb_dat_i[IRQ_W-1:0] : '0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqFlag <= '0;
    end else begin
      irqFlag <= (irqFlag & ~flagClr) | flagSet;
    end
  end

  // read mux: one named word per register, or-ed under its hit;
  // unmapped addresses hit nothing and so read zero
  logic [7:0] statusByte;
  logic [31:0] rdCtrl;
  logic [31:0] rdBal;
  logic [31:0] rdOtcfg;
  logic [31:0] rdStatus;
  logic [31:0] rdFlag;
  logic [31:0] rdMask;
  logic [31:0] rdGate;
  assign statusByte = {2'h0, gateCtrl, asleep, balLock, otStatus, wakeStatus};
  assign rdCtrl = {{(31-SLP_HI_BIT){1'b0}}, sleepSel, {SLP_LO_BIT{1'b0}}};
  assign rdBal = {24'h0, balReg};
  assign rdOtcfg = (32'(otEnable) << OT_EN_BIT) | (32'(otAction) << OT_ACT_BIT);
  assign rdStatus = {24'h0, statusByte};
  assign rdFlag = 32'(irqFlag);
  assign rdMask = 32'(irqMask);
  assign rdGate = 32'(gateCtrl) << GATE_BIT;
  assign rdData = ({32{hitCtrl}} & rdCtrl)
    | ({32{hitBal}} & rdBal)
    | ({32{hitOtcfg}} & rdOtcfg)
    | ({32{hitStatus}} & rdStatus)
    | ({32{hitFlag}} & rdFlag)
    | ({32{hitMask}} & rdMask)
    | ({32{hitGate}} & rdGate);

  // single-wait-state slave: ack one cycle after request; the !ack in
  // access keeps a held strobe from being taken twice
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= access;
    end
  end

  // read data stands only beside ack and is zero otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h0;
    end else begin
      wb_dat_o <= access ? rdData : 32'h0;
    end
  end
  assign wb_ack_o = ack;

  // outputs; sleep shuts regulator, charge gate and balance down, irq stays live
  // registered, so each output trails the mode change by one cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regulator_output <= 1'b1;
      charge_gate_out <= 1'b0;
      balance_switch_bits <= BAL_ALL_OFF;
      irq <= 1'b0;
    end else begin
      regulator_output <= !asleep;
      charge_gate_out <= !asleep && gateCtrl;
      balance_switch_bits <= asleep ? BAL_ALL_OFF : balReg;
      irq <= |(irqFlag & ~irqMask);
    end
  end

endmodule // cell_monitor_ctrl
`default_nettype wire

// ### testbench/cell_monitor_checker.sv
// bus, sleep and wake checker for the cell monitor control block
`timescale 1ns/1ps
`default_nettype none
module cell_monitor_checker #(
  parameter int WAKE_COUNT = 8 // qualifying wake width in clocks
) (
  input wire logic clk_sys, // system clock
  input wire logic rst, // async reset
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_we_i, // write enable
  input wire logic [3:0] wb_sel_i, // byte selects
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_ack_o, // acknowledge
  input wire logic hv_wake_pin_a, // wake pin a
  input wire logic hv_wake_pin_b, // wake pin b
  input wire logic overtemp_hot, // hot level
  input wire logic overtemp_cool, // cool level
  input wire logic regulator_output, // regulator enable
  input wire logic charge_gate_out, // charge gate drive
  input wire logic [7:0] balance_switch_bits, // balance drives
  input wire logic irq // interrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [15:0] cntA;
  logic [15:0] cntB;
  // raw run length of each wake pin, saturating so a long hold never wraps
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cntA <= 16'h0000;
      cntB <= 16'h0000;
    end else begin
      cntA <= hv_wake_pin_a ? cntA + 16'(cntA != 16'hffff) : 16'h0000;
      cntB <= hv_wake_pin_b ? cntB + 16'(cntB != 16'hffff) : 16'h0000;
    end
  end
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_asleep;
    !regulator_output ##1 !regulator_output;
  endsequence
  a_ack_latency: assert property (s_taken |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  a_sleep_quiet: assert property (s_asleep |-> !charge_gate_out && balance_switch_bits == 8'h00)
    else $error("output live in sleep");
  a_wake_qualify: assert property ($rose(regulator_output) |-> cntA >= WAKE_COUNT || cntB >= WAKE_COUNT)
    else $error("wake on short pulse");
  a_wake_restore: assert property (cntA == WAKE_COUNT + 5 || cntB == WAKE_COUNT + 5 |-> regulator_output)
    else $error("no wake on long pulse");
  // the pins pass two flops, then the mode flop and the output flop, so the pin sample
  // that decided the sleep write lies four edges before the fall is seen
  a_sleep_guard: assert property ($fell(regulator_output) |->
    !$past(hv_wake_pin_a || hv_wake_pin_b, 4))
    else $error("sleep entered with wake high");
endmodule // cell_monitor_checker
bind cell_monitor_ctrl cell_monitor_checker #(.WAKE_COUNT(WAKE_COUNT)) u_checker (.clk_sys, .rst, .wb_adr_i,
  .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .hv_wake_pin_a, .hv_wake_pin_b,
  .overtemp_hot, .overtemp_cool, .regulator_output, .charge_gate_out, .balance_switch_bits, .irq);
`default_nettype wire

// ### testbench/host_model.sv
// host controller model, a classic wishbone master
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_sys, // bus clock
  input wire logic ack, // slave acknowledge
  output logic [7:0] adr, // byte address
  output logic [31:0] dat, // write data
  output logic we, // write enable
  output logic cs // cyc and stb together
);
  initial begin
    cs = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h0;
  end
  // request held until ack is sampled; stale data inverted so it never looks valid
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    cs <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk_sys); while (ack !== 1'b1);
    cs <= 1'b0;
    we <= 1'b0;
    dat <= ~dat;
    @(posedge clk_sys);
  endtask
endmodule // host_model
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the cell monitor control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cell_monitor_pkg::*;
  logic clkSys = 1'b0, rst = 1'b1, wbWe, wbCs, wbAck, hvA = 1'b0, hvB = 1'b0, hot = 1'b0, cool = 1'b0;
  logic regOut, gateOut, irq;
  logic [7:0] wbAdr, balBits, b;
  logic [31:0] wbDat, rdDat, exp;
  logic [31:0] expq[$];
  int errorCnt = 0, checkCount = 0;
  cell_monitor_ctrl #(.WAKE_COUNT(8)) u_cell_monitor_ctrl (.clk_sys(clkSys), .rst(rst), .wb_adr_i(wbAdr),
    .wb_dat_i(wbDat), .wb_dat_o(rdDat), .wb_we_i(wbWe), .wb_sel_i(4'hf), .wb_cyc_i(wbCs), .wb_stb_i(wbCs),
    .wb_ack_o(wbAck), .hv_wake_pin_a(hvA), .hv_wake_pin_b(hvB), .overtemp_hot(hot), .overtemp_cool(cool),
    .regulator_output(regOut), .charge_gate_out(gateOut), .balance_switch_bits(balBits), .irq(irq));
  host_model u_host_model (.clk_sys(clkSys), .ack(wbAck), .adr(wbAdr), .dat(wbDat), .we(wbWe), .cs(wbCs));
  initial forever #20 clkSys = ~clkSys;
  task automatic cmp(input logic [31:0] got, input logic [31:0] e, input string m);
    checkCount++;
    if (got !== e) begin
      errorCnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic testDone();
    if (errorCnt == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host_model.xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    u_host_model.xfer(a, 1'b0, 8'h00);
  endtask
  // settle one time unit past the edge so registered outputs have landed
  task automatic w(input int n);
    repeat (n) @(posedge clkSys);
    #1;
  endtask
  // read data checked at the ack edge against the oldest note
  always @(posedge clkSys) begin
    if (wbAck === 1'b1 && wbWe === 1'b0) begin
      exp = expq.pop_front();
      cmp(rdDat, exp, "read data");
    end
  end
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #400000;
    errorCnt++;
    testDone();
  end
  initial begin
    void'($urandom(36034));
    b = 8'($urandom_range(255, 1));
    repeat (4) @(posedge clkSys);
    rst <= 1'b0;
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_IRQMASK, 32'(MASK_RESET));
    rd(ADDR_BAL, 32'(BAL_RESET));
    wr(8'h30, 8'hff);
    rd(8'h30, 32'h0);
    wr(ADDR_GATE, 8'h01);
    wr(ADDR_BAL, b);
    w(1);
    cmp({regOut, gateOut, balBits}, {2'b11, b}, "gate and balance drive");
    @(posedge clkSys) hvA <= 1'b1;
    w(4);
    rd(ADDR_STATUS, 32'h21);
    wr(ADDR_CTRL, {SLP_ENTER, 6'h0});
    w(2);
    cmp({regOut, balBits}, {1'b1, b}, "sleep taken with wake high");
    rd(ADDR_CTRL, 32'h0);
    @(posedge clkSys) hvA <= 1'b0;
    w(4);
    rd(ADDR_STATUS, 32'h20);
    wr(ADDR_CTRL, {SLP_ENTER, 6'h0});
    w(2);
    cmp({regOut, gateOut, balBits}, 10'h0, "outputs in sleep");
    @(posedge clkSys) hvB <= 1'b1;
    repeat (5) @(posedge clkSys);
    hvB <= 1'b0;
    w(20);
    cmp(regOut, 1'b0, "woke on short pulse");
    @(posedge clkSys) hvB <= 1'b1;
    w(14);
    cmp(regOut, 1'b1, "no wake on long pulse");
    @(posedge clkSys) hvB <= 1'b0;
    rd(ADDR_BAL, 32'h0);
    wr(ADDR_IRQFLAG, 8'h03);
    wr(ADDR_GATE, 8'h00);
    wr(ADDR_IRQMASK, 8'h02);
    wr(ADDR_OTCFG, 8'h90);
    wr(ADDR_BAL, 8'h0f);
    @(posedge clkSys) hot <= 1'b1;
    w(4);
    cmp({irq, balBits}, 9'h100, "over-temp trip");
    @(posedge clkSys) hot <= 1'b0;
    wr(ADDR_BAL, 8'h01);
    w(1);
    cmp(balBits, 8'h00, "locked switch turned on");
    rd(ADDR_STATUS, 32'h0c);
    @(posedge clkSys) cool <= 1'b1;
    w(4);
    rd(ADDR_STATUS, 32'h08);
    @(posedge clkSys) cool <= 1'b0;
    rd(ADDR_IRQFLAG, 32'h1);
    wr(ADDR_IRQFLAG, 8'h01);
    w(1);
    cmp(irq, 1'b0, "flag not cleared");
    wr(ADDR_BAL, 8'h00);
    wr(ADDR_BAL, 8'h01);
    w(1);
    cmp(balBits, 8'h01, "lock not released");
    wr(ADDR_IRQMASK, 8'h03);
    @(posedge clkSys) hot <= 1'b1;
    w(4);
    cmp({irq, gateOut, balBits}, 10'h000, "masked trip");
    rd(ADDR_IRQFLAG, 32'h0);
    wr(ADDR_OTCFG, 8'h00);
    wr(ADDR_BAL, 8'h00);
    wr(ADDR_BAL, b);
    w(4);
    cmp(balBits, b, "detection while disabled");
    rd(ADDR_STATUS, 32'h0);
    wr(ADDR_IRQMASK, 8'h01);
    @(posedge clkSys) hvA <= 1'b1;
    w(4);
    cmp(irq, 1'b1, "wake flag not raised");
    rd(ADDR_IRQFLAG, 32'h2);
    @(posedge clkSys) hvA <= 1'b0;
    wr(ADDR_IRQFLAG, 8'h02);
    w(1);
    cmp(irq, 1'b0, "wake flag not cleared");
    testDone();
  end
endmodule // testbench
`default_nettype wire
